// *** tb_two_wire_master_tx_rx_sequencer.sv ***
// self-checking bench: avalon-mm software model plus one bus slave
// assumes the 2-cycle register access and 50-cycle half bit of the design
`timescale 1ns/1ps
module tb_two_wire_master_tx_rx_sequencer;
   import tw_pkg::*;
   localparam logic [7:0] C_GO    = 8'h84;
   localparam logic [7:0] C_START = 8'ha4;
   localparam logic [7:0] C_STOP  = 8'h94;
   localparam logic [7:0] C_BOTH  = 8'hb4;
   localparam logic [7:0] C_ACK   = 8'hc4;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        scl_out, scl_oe, sda_out, sda_oe, irq, s_sda_oe;
   logic        fight = 1'b0;
   logic [7:0]  s_last, q;
   wire logic   scl_w, sda_w;
   int          n_errors = 0;
   int          check_count = 0;
   // ************************************************************
   // clock, wired-and bus, instances
   // ************************************************************
   always #50 clk = ~clk;
   assign scl_w = !(scl_oe && !scl_out);
   assign sda_w = !((sda_oe && !sda_out) || s_sda_oe);
   tw_master u_dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .irq(irq));
   tw_slave_model u_slave (.scl(scl_w), .sda(sda_w), .fight(fight),
      .sda_oe(s_sda_oe), .last_rx(s_last));
   // ************************************************************
   // shared tasks
   // ************************************************************
   task check(input string name, input logic [31:0] seen,
              input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // request held until waitrequest is sampled low
   task bus(input logic [3:0] a, input logic wr, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) check("waitrequest", 1, 0);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task rd_status(input logic [7:0] exp);
      bus(ADDR_STATE, 1'b0, 8'h00);
      check("status", q & 8'hf8, exp);
   endtask
   task wait_bit(input int b, input logic v);
      int n;
      n = 0;
      do begin
         bus(ADDR_CONTROL, 1'b0, 8'h00);
         n++;
      end while (q[b] !== v && n < 3000);
      check("control bit", q[b], v);
   endtask
   task step(input logic [7:0] v, input logic [7:0] exp);
      bus(ADDR_CONTROL, 1'b1, v);
      wait_bit(BIT_FLAG, 1'b1);
      rd_status(exp);
   endtask
   // stop bit self-clears, then one bit time for the line to settle
   task finish_stop;
      bus(ADDR_CONTROL, 1'b1, C_STOP);
      wait_bit(BIT_STOP, 1'b0);
      repeat (100) @(posedge clk);
      check("bus free", {scl_w, sda_w}, 2'b11);
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task t_idle;
      rd_status(ST_IDLE);
      bus(4'hc, 1'b0, 8'h00);
      check("unmapped", q, 8'h00);
      check("irq idle", irq, 1'b0);
      check("pads low", {scl_out, sda_out}, 2'b00);
      bus(ADDR_BUFFER, 1'b1, 8'h11);
      bus(ADDR_CONTROL, 1'b0, 8'h00);
      check("collision", q[BIT_WCOL], 1'b1);
      bus(ADDR_CONTROL, 1'b1, 8'ha8); // start without enable
      repeat (300) @(posedge clk);
      bus(ADDR_CONTROL, 1'b0, 8'h00);
      check("collision cleared", q[BIT_WCOL], 1'b0);
      rd_status(ST_IDLE);
      check("no clock", scl_oe, 1'b0);
   endtask
   task t_write;
      int i;
      step(C_START | 8'h01, ST_START);
      check("irq", irq, 1'b1);
      check("scl held", scl_w, 1'b0);
      bus(ADDR_BUFFER, 1'b1, {7'h2a, 1'b0});
      step(C_GO, ST_AW_ACK);
      check("irq cleared", irq, 1'b0);
      for (i = 0; i < 3; i++) begin
         bus(ADDR_BUFFER, 1'b1, 8'(8'h30 + i));
         step(C_GO, (i < 2) ? ST_DT_ACK : ST_DT_NACK);
         check("tx byte", s_last, 8'(8'h30 + i));
      end
      step(C_START, ST_RSTART);
      finish_stop();
   endtask
   task t_read;
      step(C_START, ST_START);
      bus(ADDR_BUFFER, 1'b1, {7'h2a, 1'b1});
      step(C_GO, ST_AR_ACK);
      step(C_ACK, ST_DR_ACK);
      bus(ADDR_BUFFER, 1'b0, 8'h00);
      check("rx first", q, 8'h5a);
      step(C_GO, ST_DR_NACK);
      bus(ADDR_BUFFER, 1'b0, 8'h00);
      check("rx last", q, 8'h5b);
      step(C_START, ST_RSTART);
      bus(ADDR_BUFFER, 1'b1, {7'h15, 1'b1});
      step(C_GO, ST_AR_NACK);
      step(C_BOTH, ST_START);
      bus(ADDR_CONTROL, 1'b0, 8'h00);
      check("stop cleared", q[BIT_STOP], 1'b0);
      finish_stop();
   endtask
   task t_arb;
      fight <= 1'b1;
      step(C_START, ST_START);
      bus(ADDR_BUFFER, 1'b1, {7'h2a, 1'b0});
      step(C_GO, ST_ARB_LOST);
      // clear in 0x38 with start: wait for the rival, then start
      bus(ADDR_CONTROL, 1'b1, C_START);
      repeat (300) @(posedge clk);
      check("waits busy bus", {scl_oe, sda_oe}, 2'b00);
      fight <= 1'b0;
      wait_bit(BIT_FLAG, 1'b1);
      rd_status(ST_START);
      // second loss, this time cleared without start
      bus(ADDR_BUFFER, 1'b1, {7'h2a, 1'b0});
      fight <= 1'b1;
      step(C_GO, ST_ARB_LOST);
      bus(ADDR_CONTROL, 1'b1, C_GO);
      repeat (20) @(posedge clk);
      check("released", {scl_oe, sda_oe}, 2'b00);
      fight <= 1'b0;
      repeat (5) @(posedge clk);
      check("bus idle", {scl_w, sda_w}, 2'b11);
   endtask
   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_idle();
      t_write();
      t_read();
      t_arb();
      end_of_test();
   end
   // whole run needs about 10k cycles; allow about six times that
   initial begin
      #6000000;
      n_errors++;
      $display("Error watchdog expected done seen hang");
      end_of_test();
   end
endmodule

// *** tw_master.sv ***
// two-wire master sequencer with avalon-mm registers
// assumes open-drain pads outside; serial inputs come from another domain
`timescale 1ns/1ps
// What this block does
// R01: data acked in transmit gives flag, 0x28
// R02: data nacked in transmit gives flag, 0x30
// R03: plain clear in 28/30 sends loaded byte
// R04: start request in data state: repeated start
// R05: stop request sends stop, self-clears
// R06: both requests: stop then start
// R07: lost arbitration reports 0x38
// R08: clear in 0x38 releases bus
// R09: start in 0x38 waits bus free
// R10: address direction bit selects tx or rx
// R11: start request begins once bus free
// R12: start sent gives flag, 0x08
// R13: software loads read address then clears
// R14: read address gives 0x38, 0x40, 0x48
// R15: received byte readable while flag set
// R16: software nacks last received byte
// R17: software ends with stop request
// R18: repeated start reports 0x10
// R19: writing one clears flag; enable gates
// R20: software masks prescaler bits
// R21: ack_enable picks ack or nack reply
// R22: buffer write while flag low: collision
// R23: nacked received byte reports 0x58
// R24: interrupt while flag set and enabled
// R25: flag holds serial clock low, except after lost arbitration (0x38), where scl is released
module tw_master
   import tw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             irq
);
   // ************************************************************
   // state record
   // ************************************************************
   typedef struct packed {
      logic [1:0]   scl_s, sda_s;    // two-stage synchronisers
      logic         scl_q, sda_q;    // last synced level
      logic         busy;            // bus seen busy by other master
      tw_phase_type ph;
      logic [7:0]   cnt;
      logic [3:0]   bit_i;
      logic [7:0]   shreg;
      logic         rx;              // master receive mode
      logic         addr_ph;         // current byte is an address
      logic         flag, ack_en, start_request_col, stop_request_col, wcol, en, ie;
      logic [7:0]   code, buf_q;
      logic         rx_ack;          // sampled ack (low = ack)
      logic         restart_after;   // start after stop
      logic         was_master;
      logic [31:0]  rdata;
      logic         wait_q;
      logic         scl_drv, sda_drv, irq_q;
      logic         sda_nx;          // next data level, applied scl low
   } tw_state_type;
   tw_state_type st_reg, st_next;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
      hit = (a == b);
   endfunction

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      logic s_scl, s_sda, wr_ctl, sets;
      s_scl = 1'b0; s_sda = 1'b0; wr_ctl = 1'b0; sets = 1'b0;
      st_next = st_reg;
      st_next.scl_s = {st_reg.scl_s[0], scl_in};
      st_next.sda_s = {st_reg.sda_s[0], sda_in};
      s_scl = st_reg.scl_s[1];
      s_sda = st_reg.sda_s[1];
      st_next.scl_q = s_scl;
      st_next.sda_q = s_sda;
      // foreign start/stop tracking, only when we are not driving
      if (st_reg.ph == S_IDLE || st_reg.ph == S_WAIT_FREE) begin
         if (s_scl && st_reg.sda_q && !s_sda) st_next.busy = 1'b1;
         if (s_scl && !st_reg.sda_q && s_sda) st_next.busy = 1'b0;
      end
      // bus slave: one wait cycle, answer on the second
      st_next.wait_q = 1'b1;
      if ((avs_read || avs_write) && st_reg.wait_q)
         st_next.wait_q = 1'b0;
      if (avs_read && st_reg.wait_q) begin
         st_next.rdata = 32'h0;
         if (hit(avs_address, ADDR_CONTROL))
            st_next.rdata[7:0] = {st_reg.flag, st_reg.ack_en, st_reg.start_request_col,
               st_reg.stop_request_col, st_reg.wcol, st_reg.en, 1'b0, st_reg.ie};
         else if (hit(avs_address, ADDR_STATE))
            st_next.rdata[7:0] = st_reg.code;
         else if (hit(avs_address, ADDR_BUFFER))
            st_next.rdata[7:0] = st_reg.buf_q;  // [R15]
      end
      if (avs_write && st_reg.wait_q) begin
         if (hit(avs_address, ADDR_CONTROL)) begin
            wr_ctl = 1'b1;
            st_next.ack_en = avs_writedata[BIT_ACK];
            st_next.start_request_col    = avs_writedata[BIT_START];
            st_next.stop_request_col    = avs_writedata[BIT_STOP];
            st_next.en     = avs_writedata[BIT_EN];       // [R19]
            st_next.ie     = avs_writedata[BIT_IE];
            if (avs_writedata[BIT_WCOL]) st_next.wcol = 1'b0;
            if (avs_writedata[BIT_FLAG]) st_next.flag = 1'b0;  // [R19]
         end else if (hit(avs_address, ADDR_BUFFER)) begin
            if (st_reg.flag) st_next.buf_q = avs_writedata[7:0];
            else st_next.wcol = 1'b1;                          // [R22]
         end
      end
      // sequencer
      if (st_reg.cnt != 8'h0) st_next.cnt = st_reg.cnt - 8'h1;
      case (st_reg.ph)
         S_IDLE: begin
            st_next.scl_drv = 1'b0; st_next.sda_drv = 1'b0;
            if (wr_ctl && avs_writedata[BIT_FLAG] && avs_writedata[BIT_EN]
                && avs_writedata[BIT_START])
               st_next.ph = S_WAIT_FREE;                        // [R11]
         end
         S_WAIT_FREE:
            if (!st_reg.busy && s_scl && s_sda) begin           // [R09]
               st_next.ph = S_START_A; st_next.cnt = HALF_CYC;
            end
         S_START_A: if (st_reg.cnt == 8'h0) begin
            st_next.sda_drv = 1'b1;          // sda falls while scl high
            st_next.ph = S_START_B; st_next.cnt = HALF_CYC;
         end
         S_START_B: if (st_reg.cnt == 8'h0) begin
            st_next.scl_drv = 1'b1; sets = 1'b1; st_next.start_request_col = 1'b0;
            st_next.code = st_reg.was_master ? ST_RSTART : ST_START;  // [R12][R18]
            st_next.was_master = 1'b1;
            st_next.addr_ph = 1'b1; st_next.rx = 1'b0;
         end
         // data moves one cycle after scl falls, never with the edge,
         // so no slave can mistake the change for a start or stop
         S_BIT_LO: begin
            st_next.sda_drv = st_reg.sda_nx;
            if (st_reg.cnt == 8'h0) begin
               st_next.scl_drv = 1'b0;
               st_next.ph = S_BIT_HI; st_next.cnt = HALF_CYC;
            end
         end
         S_BIT_HI: if (st_reg.cnt == 8'h0 && s_scl) begin
            st_next.scl_drv = 1'b1;
            st_next.ph = S_BIT_LO; st_next.cnt = HALF_CYC;
            st_next.bit_i = st_reg.bit_i + 4'h1;
            if (st_reg.bit_i != BITS_LAST) begin
               if (!st_reg.rx && !st_reg.sda_drv && !s_sda) begin
                  sets = 1'b1; st_next.code = ST_ARB_LOST;   // [R07]
                  st_next.was_master = 1'b0; st_next.scl_drv = 1'b0;
                  st_next.ph = S_HOLD;
               end
               st_next.shreg = {st_reg.shreg[6:0], s_sda};
               st_next.sda_nx = 1'b0;
               if (st_reg.bit_i + 4'h1 == BITS_LAST)
                  st_next.sda_nx = st_reg.rx & st_reg.ack_en;  // [R21]
               else if (!st_reg.rx)
                  st_next.sda_nx = ~st_reg.shreg[6];
            end else begin
               // ack level kept while scl is held; let go with scl low
               sets = 1'b1;
               st_next.addr_ph = 1'b0;
               if (st_reg.addr_ph) begin
                  st_next.rx = st_reg.shreg[0];             // [R10]
                  if (st_reg.shreg[0])
                     st_next.code = s_sda ? ST_AR_NACK : ST_AR_ACK;  // [R14]
                  else
                     st_next.code = s_sda ? ST_AW_NACK : ST_AW_ACK;
               end else if (st_reg.rx) begin
                  st_next.buf_q = st_reg.shreg;
                  st_next.code = st_reg.ack_en ? ST_DR_ACK : ST_DR_NACK; // [R23]
               end else
                  st_next.code = s_sda ? ST_DT_NACK : ST_DT_ACK;  // [R01][R02]
            end
         end
         S_HOLD: begin                                  // [R25]
            if (wr_ctl && avs_writedata[BIT_FLAG]) begin
               if (!st_reg.was_master) begin
                  st_next.ph = avs_writedata[BIT_START] ? S_WAIT_FREE
                                                       : S_IDLE;  // [R08][R09]
                  st_next.scl_drv = 1'b0; st_next.sda_drv = 1'b0;
               end else if (avs_writedata[BIT_STOP]) begin  // [R05][R06]
                  st_next.restart_after = avs_writedata[BIT_START];
                  st_next.sda_drv = 1'b1;
                  st_next.ph = S_STOP_A; st_next.cnt = HALF_CYC;
               end else if (avs_writedata[BIT_START]) begin     // [R04]
                  st_next.sda_drv = 1'b0;
                  st_next.scl_drv = 1'b1;
                  st_next.ph = S_STOP_C; st_next.cnt = HALF_CYC;
               end else begin                                   // [R03]
                  st_next.bit_i = BITS_ZERO;
                  st_next.shreg = st_reg.rx ? 8'h0 : st_reg.buf_q;
                  st_next.sda_drv = st_reg.rx ? 1'b0 : ~st_reg.buf_q[7];
                  st_next.sda_nx  = st_reg.rx ? 1'b0 : ~st_reg.buf_q[7];
                  st_next.ph = S_BIT_LO; st_next.cnt = HALF_CYC;
               end
            end
         end
         S_STOP_A: if (st_reg.cnt == 8'h0) begin
            st_next.scl_drv = 1'b0; st_next.ph = S_STOP_B;
            st_next.cnt = HALF_CYC;
         end
         S_STOP_B: if (st_reg.cnt == 8'h0 && s_scl) begin
            st_next.sda_drv = 1'b0; st_next.stop_request_col = 1'b0;     // [R05]
            st_next.was_master = 1'b0;
            st_next.ph = st_reg.restart_after ? S_WAIT_FREE : S_IDLE; // [R06]
         end
         S_STOP_C: if (st_reg.cnt == 8'h0) begin  // release scl for restart
            st_next.scl_drv = 1'b0;
            st_next.ph = S_START_A; st_next.cnt = HALF_CYC;
         end
         default: st_next.ph = S_IDLE;
      endcase
      if (sets) begin
         st_next.flag = 1'b1;                      // set wins over clear
         if (st_next.ph != S_IDLE) st_next.ph = S_HOLD;
      end
      if (!st_next.en) begin                                     // [R19]
         st_next.ph = S_IDLE; st_next.scl_drv = 1'b0;
         st_next.sda_drv = 1'b0; st_next.was_master = 1'b0;
         st_next.code = ST_IDLE;
      end
      st_next.irq_q = st_next.flag & st_next.ie;                // [R24]
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
         st_reg.scl_s <= 2'b11;
         st_reg.sda_s <= 2'b11;
         st_reg.scl_q <= 1'b1;
         st_reg.sda_q <= 1'b1;
         st_reg.wait_q <= 1'b1;
         st_reg.code <= ST_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign avs_readdata    = st_reg.rdata;
   assign avs_waitrequest = st_reg.wait_q;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = st_reg.scl_drv;
   assign sda_oe  = st_reg.sda_drv;
   assign irq     = st_reg.irq_q;

   // ************************************************************
   // checks
   // ************************************************************
   property p_irq;
      @(posedge clk) disable iff (!resetn)
      irq |-> $past(st_reg.flag && st_reg.ie) || st_reg.flag;
   endproperty
   a_irq: assert property (p_irq) else $error("irq without flag"); // [R24]
   property p_hold;
      @(posedge clk) disable iff (!resetn)
      (st_reg.ph == S_HOLD && st_reg.was_master) |-> scl_oe;
   endproperty
   a_hold: assert property (p_hold) else $error("scl not held"); // [R25]
   property p_wcol;
      @(posedge clk) disable iff (!resetn)
      (avs_write && st_reg.wait_q && avs_address == ADDR_BUFFER
       && !st_reg.flag) |=> st_reg.wcol;
   endproperty
   a_wcol: assert property (p_wcol) else $error("no collision"); // [R22]
   property p_start;
      @(posedge clk) disable iff (!resetn)
      (st_reg.ph == S_START_B && st_reg.cnt == 8'h0 && st_reg.en)
      |=> st_reg.flag && (st_reg.code == ST_START
                          || st_reg.code == ST_RSTART);
   endproperty
   a_start: assert property (p_start) else $error("bad start code"); // [R12]
   property p_stop;
      @(posedge clk) disable iff (!resetn)
      (st_reg.ph == S_STOP_B && st_next.ph != S_STOP_B && st_reg.en)
      |=> !st_reg.stop_request_col;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not cleared"); // [R05]
   logic sets_any;
   assign sets_any = st_next.flag && st_reg.ph != S_HOLD;
   property p_flagclr;
      @(posedge clk) disable iff (!resetn)
      (avs_write && st_reg.wait_q && avs_address == ADDR_CONTROL
       && avs_writedata[BIT_FLAG] && !sets_any) |=> !st_reg.flag;
   endproperty
   a_flagclr: assert property (p_flagclr) else $error("flag stuck"); // [R19]
   property p_wait;
      @(posedge clk) disable iff (!resetn)
      (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("bus hang");
   property p_en;
      @(posedge clk) disable iff (!resetn)
      !st_reg.en |-> !scl_oe && !sda_oe;
   endproperty
   a_en: assert property (p_en) else $error("drive while off"); // [R19]
   c_start: cover property (@(posedge clk) st_reg.code == ST_START);
   c_rx:    cover property (@(posedge clk) st_reg.code == ST_DR_NACK);
   c_arb:   cover property (@(posedge clk) st_reg.code == ST_ARB_LOST);
endmodule

// *** tw_pkg.sv ***
// package for the two-wire master sequencer: register map, codes, timing
// assumes a 10 MHz system clock and a 32-bit avalon-mm register bus
package tw_pkg;
   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATE   = 4'h4;
   localparam logic [3:0] ADDR_BUFFER  = 4'h8;
   // control bit positions
   localparam int BIT_FLAG  = 7;
   localparam int BIT_ACK   = 6;
   localparam int BIT_START = 5;
   localparam int BIT_STOP  = 4;
   localparam int BIT_WCOL  = 3;
   localparam int BIT_EN    = 2;
   localparam int BIT_IE    = 0;
   // ************************************************************
   // status codes
   // ************************************************************
   localparam logic [7:0] ST_START    = 8'h08;
   localparam logic [7:0] ST_RSTART   = 8'h10;
   localparam logic [7:0] ST_AW_ACK   = 8'h18;
   localparam logic [7:0] ST_AW_NACK  = 8'h20;
   localparam logic [7:0] ST_DT_ACK   = 8'h28;
   localparam logic [7:0] ST_DT_NACK  = 8'h30;
   localparam logic [7:0] ST_ARB_LOST = 8'h38;
   localparam logic [7:0] ST_AR_ACK   = 8'h40;
   localparam logic [7:0] ST_AR_NACK  = 8'h48;
   localparam logic [7:0] ST_DR_ACK   = 8'h50;
   localparam logic [7:0] ST_DR_NACK  = 8'h58;
   localparam logic [7:0] ST_IDLE     = 8'hf8;
   // ************************************************************
   // timing: half period of the generated serial clock
   // ************************************************************
   localparam int  HALF_NS     = 5000;
   localparam int  CLK_NS      = 100;
   localparam logic [7:0] HALF_CYC = 8'((HALF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] BITS_LAST = 4'h8;
   localparam logic [3:0] BITS_ZERO = 4'h0;
   typedef enum logic [3:0] {
      S_IDLE, S_WAIT_FREE, S_START_A, S_START_B, S_BIT_LO, S_BIT_HI,
      S_HOLD, S_STOP_A, S_STOP_B, S_STOP_C
   } tw_phase_type;
endpackage

// *** tw_slave_model.sv ***
// behavioural slave on the far side of the two-wire bus
// assumes pull-ups on both lines; the bench forms the wired-and levels
`timescale 1ns/1ps
module tw_slave_model #(
   parameter logic [6:0] OWN_ADDR  = 7'h2a,
   parameter int         ACK_LIMIT = 2
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       fight,
   output logic            sda_oe,
   output logic [7:0]      last_rx
);
   int         cnt     = 0;
   int         nb      = 0;
   logic [7:0] sh      = 8'h00;
   logic [7:0] tx      = 8'h00;
   logic       is_addr = 1'b0;
   logic       sel     = 1'b0;
   logic       rd      = 1'b0;
   initial sda_oe  = 1'b0;
   initial last_rx = 8'h00;
   // ************************************************************
   // framing
   // ************************************************************
   // start: sda falls while scl high; stop: sda rises while scl high
   always @(negedge sda) begin
      if (scl) begin
         cnt = -1;
         is_addr = 1'b1;
         sel = 1'b0;
      end
   end
   always @(posedge sda) begin
      if (scl) begin
         sel = 1'b0;
      end
   end
   // a rival master letting go of sda frees the bus
   always @(negedge fight) sda_oe = 1'b0;
   // sample on rising scl; a master nack ends the read
   always @(posedge scl) begin
      if (cnt >= 0 && cnt < 8) sh = {sh[6:0], sda};
      if (cnt == 8 && sel && rd && !is_addr && sda) sel = 1'b0;
   end
   // ************************************************************
   // driving after falling scl
   // ************************************************************
   // changes only while scl is low, so no false start or stop
   always @(negedge scl) begin
      if (cnt == 8) begin
         cnt = 0;
         is_addr = 1'b0;
      end else begin
         cnt = cnt + 1;
      end
      tx = 8'h5a + 8'(nb);
      if (fight && is_addr) begin
         sda_oe = 1'b1; // rival holds sda low, wins any one bit
      end else if (cnt == 8 && is_addr) begin
         sel = (sh[7:1] == OWN_ADDR);
         rd = sh[0];
         nb = 0;
         sda_oe = sel;
      end else if (cnt == 8 && sel && !rd) begin
         last_rx = sh;
         sda_oe = (nb < ACK_LIMIT); // nack once the limit is reached
         nb = nb + 1;
      end else if (sel && rd && !is_addr) begin
         sda_oe = (cnt < 8) ? !tx[7 - cnt] : 1'b0;
         if (cnt == 8) nb = nb + 1;
      end else begin
         sda_oe = 1'b0;
      end
   end
endmodule
